// [verilog/tx_event_pkg.sv]
package tx_event_pkg;
    // register byte addresses (event offset printed; enable offset chosen)
    localparam logic [9:0]  ADDR_EVENTS      = 10'h218;
    localparam logic [9:0]  ADDR_ENABLES     = 10'h106;
    // identifier fields
    localparam logic [5:0]  EVENTS_ID        = 6'h08;
    localparam logic [5:0]  ENABLES_ID       = 6'h07;
    localparam logic [15:0] EVENTS_RESET     = 16'h0008;
    localparam logic [15:0] ENABLES_RESET    = 16'h0007;
    // field positions
    localparam int          BIT_CARRIER_LOST = 6;
    localparam int          BIT_HEARTBEAT    = 7;
    localparam int          BIT_SEND_DONE    = 8;
    localparam int          BIT_LATE_COLL    = 9;
    localparam int          BIT_OVERLONG     = 10;
    localparam int          BIT_COLL_LSB     = 11;
    localparam int          BIT_EXCESS_COLL  = 15;
    // writable enable bits: 6,7,8,9,A,B,F
    localparam logic [15:0] ENABLE_MASK      = 16'h8FC0;
    // timing
    localparam int          CLK_HZ           = 50_000_000;
    localparam int          BIT_RATE_HZ      = 10_000_000;
    localparam int          CLKS_PER_BIT     = CLK_HZ / BIT_RATE_HZ;
    localparam int          HEARTBEAT_BITS   = 64;
    localparam int          LATE_COLL_BITS   = 512;
    localparam int          HEARTBEAT_CLKS   = HEARTBEAT_BITS * CLKS_PER_BIT;
    localparam int          LATE_COLL_CLKS   = LATE_COLL_BITS * CLKS_PER_BIT;
    localparam int          JABBER_MS        = 26;
    localparam int          JABBER_CLKS      = JABBER_MS * (CLK_HZ / 1000);
    localparam logic [4:0]  MAX_COLLISIONS   = 5'd16;
endpackage : tx_event_pkg

// [verilog/tx_sync2.sv]
`timescale 1ns/10ps
`default_nettype none
module tx_sync2 (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic ce,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic stage1;
    logic next_stage1;
    logic next_sync_out;

    always_comb begin
        next_stage1   = stage1;
        next_sync_out = sync_out;
        if (ce) begin
            next_stage1   = async_in;
            next_sync_out = stage1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            stage1   <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            stage1   <= next_stage1;
            sync_out <= next_sync_out;
        end
    end
endmodule : tx_sync2
`default_nettype wire

// [verilog/tx_event_status_irq.sv]
// How it works
// RULE_01 - enable register low six bits always read 000111
// RULE_02 - event register low six bits always read 001000
// RULE_03 - event register reports only the latest packet outcome
// RULE_04 - aui carrier not seen by preamble end sets bit 6
// RULE_05 - no aui collision within 64 bit times after end sets bit 7
// RULE_06 - bit 8 set when fully sent, bits 9, A, F clear
// RULE_07 - collision past 512 bit times: bad crc, abort, bit 9
// RULE_08 - transmission over 26 ms: jabber cuts output, sets bit A
// RULE_09 - collision count of last packet in bits E..B, B lsb
// RULE_10 - sixteen collisions abandon the packet and set bit F
// RULE_11 - each event interrupts only when its enable bit is set
// RULE_12 - any-collision enable interrupts on collisions during a packet
// RULE_13 - reading the event register clears all event bits
// RULE_14 - host must process every event bit it reads
// RULE_15 - enable register resets to 0x0007
// RULE_16 - event register resets to 0x0008
// RULE_17 - eeprom present may load enable register at start
// RULE_18 - a clear enable bit suppresses its interrupt
// RULE_19 - enabled pending events form one irq held until read
//
// The Avalon-MM interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module tx_event_status_irq #(
    parameter int JABBER_LIMIT = tx_event_pkg::JABBER_CLKS
) (
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        ce,
    // avalon-mm slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // transmit engine, same clock
    input  wire logic        tx_start,
    input  wire logic        tx_active,
    input  wire logic        tx_preamble_end,
    input  wire logic        tx_aui_sel,
    // eeprom load, same clock
    input  wire logic        eeprom_load,
    input  wire logic [15:0] eeprom_enables,
    // medium pins
    input  wire logic        carrier_sense,
    input  wire logic        collision_det,
    // outputs to transmit engine, and irq to the host
    output logic             tx_abort,
    output logic             tx_force_bad_crc,
    output logic             tx_jabber_cut,
    output logic             irq
);
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SEND    = 2'b01,
        ST_HBEAT   = 2'b10,
        ST_DONE    = 2'b11
    } tx_state_e;

    function automatic logic [15:0] be_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [1:0]  be);
        be_merge = {be[1] ? new_v[15:8] : old_v[15:8],
                    be[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction : be_merge

    function automatic logic hit(input logic [9:0] addr,
                                 input logic [9:0] reg_addr);
        hit = (addr == reg_addr);
    endfunction : hit

    logic crs_s;
    logic col_s;
    logic col_d;

    tx_sync2 u_sync_crs (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .ce       (ce),
        .async_in (carrier_sense),
        .sync_out (crs_s)
    );

    tx_sync2 u_sync_col (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .ce       (ce),
        .async_in (collision_det),
        .sync_out (col_s)
    );

    wire logic col_rise = col_s & ~col_d;

    // state
    tx_state_e   state;
    logic [15:0] enables;
    logic [9:0]  events;      // bits F..6
    logic [20:0] tx_timer;
    logic [9:0]  hb_timer;
    logic        aui_pkt;
    logic        coll_any;
    logic        ack;

    tx_state_e   next_state;
    logic [15:0] next_enables;
    logic [9:0]  next_events;
    logic [20:0] next_tx_timer;
    logic [9:0]  next_hb_timer;
    logic        next_aui_pkt;
    logic        next_col_d;
    logic        next_tx_abort;
    logic        next_bad_crc;
    logic        next_jabber;
    logic        next_irq;
    logic        next_coll_any;
    logic [31:0] next_rd_data;
    logic        next_ack;
    logic        next_wait;

    logic        rd_events;
    logic        wr_enables;
    logic [15:0] ev_word;
    logic [4:0]  cnt5;
    logic        late;
    logic        jab;

    always_comb begin
        ev_word = {events, tx_event_pkg::EVENTS_ID}; // RULE_02
        rd_events  = avs_read & ~ack
                   & hit(avs_address, tx_event_pkg::ADDR_EVENTS);
        wr_enables = avs_write & ~ack
                   & hit(avs_address, tx_event_pkg::ADDR_ENABLES);

        next_state    = state;
        next_enables  = enables;
        next_events   = events;
        next_tx_timer = tx_timer;
        next_hb_timer = hb_timer;
        next_aui_pkt  = aui_pkt;
        next_col_d    = col_s;
        next_tx_abort = 1'b0;
        next_bad_crc  = tx_force_bad_crc;
        next_jabber   = tx_jabber_cut;
        next_coll_any = coll_any;
        cnt5          = {1'b0, events[8:5]};
        late          = 1'b0;
        jab           = 1'b0;

        // clear on read; events from this cycle survive below
        if (rd_events) begin
            next_events   = 10'h000; // RULE_13
            next_coll_any = 1'b0;
        end
        if (wr_enables) begin
            next_enables = (be_merge(enables, avs_writedata[15:0],
                                     avs_byteenable[1:0])
                            & tx_event_pkg::ENABLE_MASK)
                           | tx_event_pkg::ENABLES_RESET; // RULE_01
        end
        if (eeprom_load) begin
            next_enables = (eeprom_enables & tx_event_pkg::ENABLE_MASK)
                           | tx_event_pkg::ENABLES_RESET; // RULE_17
        end

        unique case (state)
            ST_IDLE, ST_DONE: begin
                if (tx_start) begin
                    next_state    = ST_SEND;
                    next_events   = 10'h000; // RULE_03
                    next_coll_any = 1'b0;
                    next_tx_timer = 21'd0;
                    next_aui_pkt  = tx_aui_sel;
                    next_bad_crc  = 1'b0;
                    next_jabber   = 1'b0;
                end
            end
            ST_SEND: begin
                next_tx_timer = tx_timer + 21'd1;
                if (tx_preamble_end & aui_pkt & ~crs_s) begin
                    next_events[tx_event_pkg::BIT_CARRIER_LOST - 6] = 1'b1; // RULE_04
                end
                if (col_rise) begin
                    if (tx_timer >= 21'(tx_event_pkg::LATE_COLL_CLKS)) begin
                        late = 1'b1;
                        next_events[tx_event_pkg::BIT_LATE_COLL - 6] = 1'b1; // RULE_07
                        next_bad_crc = 1'b1; // RULE_07
                    end else begin
                        cnt5 = cnt5 + 5'd1;
                        if (cnt5[3:0] != 4'h0) begin
                            next_events[8:5] = cnt5[3:0]; // RULE_09
                        end
                        next_coll_any = 1'b1; // RULE_12
                        if (cnt5 == tx_event_pkg::MAX_COLLISIONS) begin
                            next_events[tx_event_pkg::BIT_EXCESS_COLL - 6] = 1'b1; // RULE_10
                            late = 1'b1;
                        end
                    end
                end
                if (tx_timer >= 21'(JABBER_LIMIT)) begin
                    jab = 1'b1;
                    next_jabber = 1'b1; // RULE_08
                    next_events[tx_event_pkg::BIT_OVERLONG - 6] = 1'b1; // RULE_08
                end
                if (late | jab) begin
                    next_tx_abort = 1'b1; // RULE_07 RULE_10
                    next_state    = ST_DONE;
                end else if (~tx_active) begin
                    // clean finish
                    next_events[tx_event_pkg::BIT_SEND_DONE - 6] = 1'b1; // RULE_06
                    next_hb_timer = 10'd0;
                    next_state = aui_pkt ? ST_HBEAT : ST_DONE;
                end
            end
            ST_HBEAT: begin
                next_hb_timer = hb_timer + 10'd1;
                if (col_rise) begin
                    next_state = ST_DONE;
                end else if (hb_timer >=
                             10'(tx_event_pkg::HEARTBEAT_CLKS - 1)) begin
                    next_events[tx_event_pkg::BIT_HEARTBEAT - 6] = 1'b1; // RULE_05
                    next_state = ST_DONE;
                end
            end
        endcase

        // one line, events gated by matching enables
        next_irq = |((({next_events, 6'h00} & ~16'h7800)
                      & next_enables & 16'h87C0)) // RULE_11 RULE_18
                   | (next_coll_any & next_enables[tx_event_pkg::BIT_COLL_LSB]); // RULE_12 RULE_19
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state            <= ST_IDLE;
            enables          <= tx_event_pkg::ENABLES_RESET; // RULE_15
            events           <= 10'h000; // RULE_16
            tx_timer         <= 21'd0;
            hb_timer         <= 10'd0;
            aui_pkt          <= 1'b0;
            col_d            <= 1'b0;
            tx_abort         <= 1'b0;
            tx_force_bad_crc <= 1'b0;
            tx_jabber_cut    <= 1'b0;
            irq              <= 1'b0;
            coll_any         <= 1'b0;
        end else if (ce) begin
            state            <= next_state;
            enables          <= next_enables;
            events           <= next_events;
            tx_timer         <= next_tx_timer;
            hb_timer         <= next_hb_timer;
            aui_pkt          <= next_aui_pkt;
            col_d            <= next_col_d;
            tx_abort         <= next_tx_abort;
            tx_force_bad_crc <= next_bad_crc;
            tx_jabber_cut    <= next_jabber;
            irq              <= next_irq;
            coll_any         <= next_coll_any;
        end
    end

    // bus group: the answer comes one cycle after the take
    always_comb begin
        next_ack     = 1'b0;
        next_rd_data = avs_readdata;
        if ((avs_read | avs_write) & ~ack) begin
            next_ack = 1'b1;
            if (avs_read) begin
                if (hit(avs_address, tx_event_pkg::ADDR_EVENTS)) begin
                    next_rd_data = {16'h0000, ev_word};
                end else if (hit(avs_address,
                                 tx_event_pkg::ADDR_ENABLES)) begin
                    next_rd_data = {16'h0000, enables};
                end else begin
                    // unmapped reads return zero, never x
                    next_rd_data = 32'h0000_0000;
                end
            end
        end
        // registered so the bus sees no combinational path
        next_wait = ~next_ack;
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack             <= 1'b0;
            avs_readdata    <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            ack             <= next_ack;
            avs_readdata    <= next_rd_data;
            avs_waitrequest <= next_wait;
        end
    end
endmodule : tx_event_status_irq
`default_nettype wire

// [sim/medium_model.sv]
`timescale 1ns/10ps
`default_nettype none
module medium_model (
    input  wire logic sys_clk,
    input  wire logic tx_active,
    input  wire logic carrier_on,
    input  wire logic heartbeat_on,
    input  wire logic coll_req,
    output var  logic carrier_sense,
    output var  logic collision_det
);
    int   hold  = 0;
    int   hb    = 0;
    logic was_a = 1'b0;
    // carrier only echoed while sending, never left floating high
    assign carrier_sense = tx_active && carrier_on;
    assign collision_det = hold > 0;
    always @(posedge sys_clk) begin
        was_a <= tx_active;
        if (hold > 0)
            hold <= hold - 1;
        if (hb > 1)
            hb <= hb - 1;
        if (hb == 1) begin
            hb   <= 0;
            hold <= 10;
        end
        if (coll_req)
            hold <= 4;
        // heartbeat lands well inside the listen window
        if (was_a && !tx_active && heartbeat_on)
            hb <= 50;
    end
endmodule : medium_model
`default_nettype wire

// [sim/tx_event_status_irq_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module tx_event_checker #(
    parameter int JABBER_LIMIT = 4000
) (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        tx_start,
    input wire logic        eeprom_load,
    input wire logic        tx_abort,
    input wire logic        tx_force_bad_crc,
    input wire logic        tx_jabber_cut,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    logic [31:0] age;
    logic [31:0] next_age;
    logic        ack;
    assign ack = avs_read && !avs_waitrequest;
    // saturates so a long idle gap never wraps under a threshold
    always_comb begin
        next_age = age;
        if (srst || tx_start)
            next_age = 32'h00000000;
        else if (age != 32'hFFFFFFFF)
            next_age = age + 32'h00000001;
    end
    always_ff @(posedge sys_clk) begin
        age <= next_age;
    end
    AST_ENABLES_ID: assert property (ack && avs_address == 10'h106
        |-> avs_readdata[5:0] == 6'h07) else $error("enable id wrong");
    AST_EVENTS_ID: assert property (ack && avs_address == 10'h218
        |-> avs_readdata[5:0] == 6'h08) else $error("event id wrong");
    AST_LATE_WINDOW: assert property ($rose(tx_force_bad_crc)
        |-> age >= 32'd2559) else $error("bad crc too early");
    AST_LATE_ABORT: assert property ($rose(tx_force_bad_crc)
        |-> ##[0:2] tx_abort) else $error("late collision no abort");
    AST_BAD_CRC_HOLD: assert property (tx_force_bad_crc && !tx_start
        |=> tx_force_bad_crc) else $error("bad crc dropped");
    AST_JABBER_TIME: assert property ($rose(tx_jabber_cut)
        |-> age + 2 >= JABBER_LIMIT && age <= JABBER_LIMIT + 4)
        else $error("jabber cut at wrong time");
    AST_JABBER_ABORT: assert property ($rose(tx_jabber_cut)
        |-> ##[0:2] tx_abort) else $error("jabber no abort");
    AST_READ_CLEARS: assert property (ack && avs_address == 10'h218
        ##1 (!tx_start && !avs_write)[*2] ##[0:4]
        (ack && avs_address == 10'h218) |-> avs_readdata[15:6] == 10'h000)
        else $error("event read did not clear");
    AST_IRQ_HOLD: assert property (irq && !avs_read && !avs_write
        && !tx_start && !$past(tx_start) && !eeprom_load
        && !$past(eeprom_load) |=> irq) else $error("irq dropped unread");
    cover property ($rose(tx_force_bad_crc));
    cover property ($rose(tx_jabber_cut));
    cover property ($fell(irq));
endmodule : tx_event_checker
bind tx_event_status_irq tx_event_checker #(.JABBER_LIMIT(JABBER_LIMIT))
    tx_event_checker_i (.sys_clk(sys_clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_start(tx_start), .eeprom_load(eeprom_load), .tx_abort(tx_abort),
    .tx_force_bad_crc(tx_force_bad_crc), .tx_jabber_cut(tx_jabber_cut),
    .irq(irq));
`default_nettype wire

// [sim/tx_event_status_irq_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module tx_event_status_irq_tb_top;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0, avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
    logic        avs_waitrequest, carrier_sense, collision_det;
    logic        tx_start = 1'b0, tx_active = 1'b0, tx_preamble_end = 1'b0;
    logic        tx_aui_sel = 1'b0, eeprom_load = 1'b0, coll_req = 1'b0;
    logic        carrier_on = 1'b0, heartbeat_on = 1'b0;
    logic [15:0] eeprom_enables = 16'h0000;
    logic        tx_abort, tx_force_bad_crc, tx_jabber_cut, irq;
    logic [31:0] rs = 32'h0000000B;
    int          num_errors = 0, num_checks = 0;
    always #10 sys_clk = ~sys_clk;
    tx_event_status_irq #(.JABBER_LIMIT(4000)) tx_event_status_irq_i (
        .sys_clk(sys_clk), .srst(srst), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h3), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_start(tx_start),
        .tx_active(tx_active), .tx_preamble_end(tx_preamble_end),
        .tx_aui_sel(tx_aui_sel), .eeprom_load(eeprom_load),
        .eeprom_enables(eeprom_enables), .carrier_sense(carrier_sense),
        .collision_det(collision_det), .tx_abort(tx_abort),
        .tx_force_bad_crc(tx_force_bad_crc),
        .tx_jabber_cut(tx_jabber_cut), .irq(irq));
    medium_model medium_model_i (.sys_clk(sys_clk), .tx_active(tx_active),
        .carrier_on(carrier_on), .heartbeat_on(heartbeat_on),
        .coll_req(coll_req), .carrier_sense(carrier_sense),
        .collision_det(collision_det));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction : xs
    function automatic logic [15:0] ev_of(input logic aui, crs, hb,
                                          late, jab, input int nc);
        logic [15:0] v;
        v        = tx_event_pkg::EVENTS_RESET;
        v[6]     = aui && !crs;
        v[7]     = aui && !hb;
        v[8]     = !late && !jab && nc < 16;
        v[9]     = late;
        v[10]    = jab;
        v[14:11] = nc[3:0];
        v[15]    = nc > 15;
        return v;
    endfunction : ev_of
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [9:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= {16'h0000, d};
        avs_write     <= w;
        avs_read      <= !w;
        @(posedge sys_clk);
        // look between edges so the value seen is the one the edge samples
        @(negedge sys_clk);
        while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        q = avs_readdata[15:0];
        @(posedge sys_clk);
        if (n < 50) begin
            avs_read  <= 1'b0;
            avs_write <= 1'b0;
            @(posedge sys_clk);
        end else begin
            num_errors++;
            test_done();
        end
    endtask : bus
    task automatic pkt(input logic aui, crs, hb, late, jab,
                       input int nc, len, input logic rd);
        logic [15:0] w, q, ev, m;
        // collision-seen enable kept off where extra collisions are vague
        w = rs[15:0] & ((aui || late) ? 16'hF7FF : 16'hFFFF);
        rs = xs(rs);
        bus(1'b1, tx_event_pkg::ADDR_ENABLES, w, q);
        bus(1'b0, tx_event_pkg::ADDR_ENABLES, 16'h0000, q);
        w = (w & 16'h8FC0) | 16'h0007;
        chk("enables", w, q);
        carrier_on   <= crs;
        heartbeat_on <= hb;
        tx_aui_sel   <= aui;
        tx_start     <= 1'b1;
        tx_active    <= 1'b1;
        @(posedge sys_clk);
        tx_start <= 1'b0;
        repeat (19) @(posedge sys_clk);
        tx_preamble_end <= 1'b1;
        @(posedge sys_clk);
        tx_preamble_end <= 1'b0;
        for (int i = 0; i < nc + late; i++) begin
            if (late && i == nc)
                repeat (2700) @(posedge sys_clk);
            coll_req <= 1'b1;
            @(posedge sys_clk);
            coll_req <= 1'b0;
            repeat (9) @(posedge sys_clk);
        end
        repeat (len) @(posedge sys_clk);
        chk("cut", {14'h0, jab, late},
            {14'h0, tx_jabber_cut, tx_force_bad_crc});
        tx_active <= 1'b0;
        repeat (400) @(posedge sys_clk);
        ev = ev_of(aui, crs, hb, late, jab, nc);
        m  = (aui || late || nc > 15) ? 16'h87FF : 16'hFFFF;
        chk("irq", {15'h0, |(ev & w & 16'h87C0) || (nc > 0 && w[11])},
            {15'h0, irq});
        if (rd) begin
            bus(1'b0, tx_event_pkg::ADDR_EVENTS, 16'h0000, q);
            chk("events", ev & m, q & m);
            bus(1'b0, tx_event_pkg::ADDR_EVENTS, 16'h0000, q);
            chk("events cleared", 16'h0008, q);
        end
    endtask : pkt
    initial begin
        logic [15:0] q;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, tx_event_pkg::ADDR_ENABLES, 16'h0000, q);
        chk("enables reset", tx_event_pkg::ENABLES_RESET, q);
        bus(1'b0, tx_event_pkg::ADDR_EVENTS, 16'h0000, q);
        chk("events reset", tx_event_pkg::EVENTS_RESET, q);
        bus(1'b0, 10'h000, 16'h0000, q);
        chk("unmapped", 16'h0000, q);
        eeprom_enables <= rs[31:16];
        eeprom_load    <= 1'b1;
        @(posedge sys_clk);
        eeprom_load <= 1'b0;
        bus(1'b0, tx_event_pkg::ADDR_ENABLES, 16'h0000, q);
        chk("eeprom", (eeprom_enables & 16'h8FC0) | 16'h0007, q);
        pkt(1, 0, 0, 0, 0, 0, 100, 1);
        pkt(1, 1, 1, 0, 0, 0, 100, 1);
        pkt(0, 1, 0, 0, 0, 16, 100, 1);
        pkt(0, 1, 0, 1, 0, 0, 50, 0);
        pkt(0, 1, 0, 0, 0, 3, 100, 1);
        pkt(0, 1, 0, 0, 1, 0, 4100, 1);
        for (int k = 0; k < 6; k++)
            pkt(rs[0], rs[1], rs[2], 0, 0, rs[6:4], 60 + rs[11:8], 1);
        test_done();
    end
endmodule : tx_event_status_irq_tb_top
`default_nettype wire
